// ### shared/io_bus_pkg.sv
// Shared constants for the two-phase exchange bus control.
// Assumes a 24-bit exchange word and one cycle-type code per command word.
package io_bus_pkg;

    // Exchange word width
    localparam int EXCH_W = 24;

    // Command word layout: cycle code, channel, data
    localparam int CODE_HI = 23;
    localparam int CODE_LO = 20;
    localparam int CHAN_HI = 19;
    localparam int CHAN_LO = 16;
    localparam int DATA_HI = 15;
    localparam int DATA_LO = 0;

    // Reply layout: status count, device identifier, present bit
    localparam int STAT_HI = 20;
    localparam int STAT_LO = 16;
    localparam int ID_HI = 15;
    localparam int ID_LO = 8;
    localparam int PRESENT_BIT = 0;

    localparam int CODE_W = CODE_HI - CODE_LO + 1;
    localparam int CHAN_W = CHAN_HI - CHAN_LO + 1;
    localparam int DATA_W = DATA_HI - DATA_LO + 1;
    localparam int STAT_W = STAT_HI - STAT_LO + 1;
    localparam int ID_W = ID_HI - ID_LO + 1;

    // Cycle type codes
    localparam logic [CODE_W-1:0] CYC_XFR_OUT_A = 4'h2;
    localparam logic [CODE_W-1:0] CYC_XFR_OUT_B = 4'h3;
    localparam logic [CODE_W-1:0] CYC_TEST_STATUS = 4'h4;
    localparam logic [CODE_W-1:0] CYC_CLEAR_TEST = 4'h5;
    localparam logic [CODE_W-1:0] CYC_POLL = 4'h6;
    localparam logic [CODE_W-1:0] CYC_TERMINATE = 4'h7;
    localparam logic [CODE_W-1:0] CYC_XFR_IN = 4'h8;

    // Status reported after a clear
    localparam logic [STAT_W-1:0] STATUS_RESET = 5'h00;

    // Reset values
    localparam logic [EXCH_W-1:0] WORD_ZERO = 24'h000000;
    localparam logic [EXCH_W-1:0] WORD_ONES = 24'hFFFFFF;
    localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
    localparam logic [1:0] SYNC_ZERO = 2'h0;
    localparam logic [1:0] SYNC_ONES = 2'h3;

    // Device identifier, value arbitrary
    localparam logic [ID_W-1:0] DEVICE_ID_DEFAULT = 8'h5A;

endpackage : io_bus_pkg

// ### design/io_bus_control.sv
// Bus side of one I/O control on the two-phase 24-bit exchange bus.
// Assumes strobes and exchange inputs synchronous to mclk; the wire level
// of the exchange lines is resolved outside from exch_out and exch_oe.
//
// Functional notes
// RL1: processor pulses command strobe for one clock to mark command phase
// RL2: processor pulses response strobe for one clock to mark response phase
// RL3: attention line stays high while this control needs service
// RL4: subsystem clear held three clocks clears control asynchronously
// RL5: control drives its own direction select, ORed outside, exchange only
// RL6: direction select low by default, raised only when returning data
// RL7: processor packs words, never more than one word per transfer
// RL8: cycle type decoded from exchange lines during command phase
// RL9: top four bits cycle code, next four channel, rest data
// RL10: transfer out A latches command, channel and sixteen data bits
// RL11: transfer out A response phase returns current status
// RL12: transfer out B captures 24 data bits when response strobe ends
// RL13: test status returns identifier, status and present bit
// RL14: clear and test resets control at command end, returns reset status
// RL15: poll makes every requesting control drive its channel bit to 1
// RL16: processor polls normally only while attention line is high
// RL17: terminate marks end of record and returns status
// RL18: transfer in drives up to sixteen data bits in response phase
// RL19: each strobe spans exactly one trailing clock edge
// RL20: processor waits 500 ns from command to response strobe; host_model waits gap clocks of 4 ns instead
// RL21: processor waits four clocks from response to next command
// RL22: processor strobes on moves to command and data pseudo registers
// RL23: every command phase is followed by a response phase
// RL24: only matching channel reacts, except poll which all obey
`timescale 1ns/1ps
`default_nettype none

module io_bus_control
    import io_bus_pkg::*;
#(
    parameter logic [ID_W-1:0] DEVICE_ID = DEVICE_ID_DEFAULT
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic subsystem_clear,
    input wire logic cmd_strobe,
    input wire logic response_strobe,
    input wire logic [EXCH_W-1:0] exch_in,
    output logic [EXCH_W-1:0] exch_out,
    output logic [EXCH_W-1:0] exch_oe,
    output logic bus_drive_select,
    output logic attention_line,
    input wire logic [CHAN_W-1:0] my_channel,
    input wire logic service_needed,
    input wire logic [STAT_W-1:0] device_status,
    input wire logic [DATA_W-1:0] in_data,
    output logic cmd_valid,
    output logic [DATA_W-1:0] cmd_data,
    output logic out_b_valid,
    output logic [EXCH_W-1:0] out_b_data,
    output logic term_pulse,
    output logic clear_pulse
);

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_RESP = 2'b11
    } phase_e;

    logic [1:0] rst_sync_r;
    logic ctl_rst_n;
    logic cmd_d_r;
    logic rsp_d_r;
    logic [EXCH_W-1:0] cmd_word_r;
    logic [EXCH_W-1:0] rsp_word_r;
    logic cmd_end;
    logic rsp_start;
    logic rsp_end;
    logic [CODE_W-1:0] new_code;
    logic hit;
    phase_e state_r;
    phase_e state_nxt;
    logic [CODE_W-1:0] cyc_r;
    logic [CODE_W-1:0] cyc_nxt;
    logic drive_nxt;

    // Known cycle code
    function automatic logic code_known(input logic [CODE_W-1:0] code);
        code_known = (code == CYC_XFR_OUT_A) || (code == CYC_XFR_OUT_B) ||
                     (code == CYC_TEST_STATUS) || (code == CYC_CLEAR_TEST) ||
                     (code == CYC_POLL) || (code == CYC_TERMINATE) ||
                     (code == CYC_XFR_IN);
    endfunction : code_known

    // Cycles that send a word back to the processor
    function automatic logic returns_data(input logic [CODE_W-1:0] code);
        returns_data = code_known(code) && (code != CYC_XFR_OUT_B);
    endfunction : returns_data

    // Reply word for every data-returning cycle except the poll
    function automatic logic [EXCH_W-1:0] reply_word(
        input logic [CODE_W-1:0] code,
        input logic [STAT_W-1:0] stat,
        input logic [DATA_W-1:0] din
    );
        reply_word = WORD_ZERO;
        unique case (code)
            CYC_XFR_OUT_A, CYC_TERMINATE: begin
                reply_word[STAT_HI:STAT_LO] = stat; // see RL11 // see RL17
            end
            CYC_TEST_STATUS: begin
                reply_word[STAT_HI:STAT_LO] = stat; // see RL13
                reply_word[ID_HI:ID_LO] = DEVICE_ID;
                reply_word[PRESENT_BIT] = 1'b1;
            end
            CYC_CLEAR_TEST: begin
                reply_word[STAT_HI:STAT_LO] = STATUS_RESET; // see RL14
                reply_word[ID_HI:ID_LO] = DEVICE_ID;
                reply_word[PRESENT_BIT] = 1'b1;
            end
            CYC_XFR_IN: begin
                reply_word[DATA_HI:DATA_LO] = din; // see RL18
            end
            default: reply_word = WORD_ZERO;
        endcase
    endfunction : reply_word

    // Reset release through two flip-flops
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rst_sync_r <= SYNC_ZERO;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end

    // Subsystem clear acts without the clock
    assign ctl_rst_n = rst_sync_r[1] & ~subsystem_clear; // see RL4

    // Strobe edges and captured words
    always_ff @(posedge mclk or negedge ctl_rst_n) begin
        if (!ctl_rst_n) begin
            cmd_d_r <= 1'b0;
            rsp_d_r <= 1'b0;
            cmd_word_r <= WORD_ZERO;
            rsp_word_r <= WORD_ZERO;
        end else begin
            cmd_d_r <= cmd_strobe;
            rsp_d_r <= response_strobe;
            if (cmd_strobe) begin
                cmd_word_r <= exch_in; // see RL8
            end
            if (response_strobe) begin
                rsp_word_r <= exch_in;
            end
        end
    end

    // Phase ends on the strobe's trailing edge
    assign cmd_end = cmd_d_r & ~cmd_strobe; // see RL1
    assign rsp_start = response_strobe & ~rsp_d_r; // see RL2
    assign rsp_end = rsp_d_r & ~response_strobe;

    // Command decode
    assign new_code = cmd_word_r[CODE_HI:CODE_LO]; // see RL9
    assign hit = code_known(new_code) &&
                 ((new_code == CYC_POLL) ||
                  (cmd_word_r[CHAN_HI:CHAN_LO] == my_channel)); // see RL24

    // Phase sequencing
    always_comb begin
        state_nxt = state_r;
        cyc_nxt = cyc_r;
        unique case (state_r)
            ST_IDLE: begin
                if (cmd_end && hit) begin
                    state_nxt = ST_WAIT;
                    cyc_nxt = new_code; // see RL8
                end
            end
            ST_WAIT: begin
                if (cmd_end) begin
                    state_nxt = hit ? ST_WAIT : ST_IDLE;
                    cyc_nxt = new_code;
                end else if (rsp_start) begin
                    state_nxt = ST_RESP;
                end
            end
            ST_RESP: begin
                if (rsp_end) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    assign drive_nxt = (state_nxt != ST_IDLE) && returns_data(cyc_nxt); // see RL6

    always_ff @(posedge mclk or negedge ctl_rst_n) begin
        if (!ctl_rst_n) begin
            state_r <= ST_IDLE;
            cyc_r <= CYC_XFR_OUT_A;
        end else begin
            state_r <= state_nxt;
            cyc_r <= cyc_nxt;
        end
    end

    // Exchange drive and direction select
    always_ff @(posedge mclk or negedge ctl_rst_n) begin
        if (!ctl_rst_n) begin
            exch_out <= WORD_ZERO;
            exch_oe <= WORD_ZERO;
            bus_drive_select <= 1'b0;
        end else begin
            bus_drive_select <= drive_nxt; // see RL5
            exch_out <= WORD_ZERO;
            exch_oe <= WORD_ZERO;
            if (drive_nxt && cyc_nxt == CYC_POLL) begin
                exch_out[my_channel] <= service_needed; // see RL15
                exch_oe[my_channel] <= service_needed;
            end else if (drive_nxt) begin
                exch_out <= reply_word(cyc_nxt, device_status, in_data);
                exch_oe <= WORD_ONES;
            end
        end
    end

    // Attention line follows the service need
    always_ff @(posedge mclk or negedge ctl_rst_n) begin
        if (!ctl_rst_n) begin
            attention_line <= 1'b0;
        end else begin
            attention_line <= service_needed; // see RL3
        end
    end

    // Data toward the device side
    always_ff @(posedge mclk or negedge ctl_rst_n) begin
        if (!ctl_rst_n) begin
            cmd_valid <= 1'b0;
            cmd_data <= DATA_ZERO;
            out_b_valid <= 1'b0;
            out_b_data <= WORD_ZERO;
            term_pulse <= 1'b0;
            clear_pulse <= 1'b0;
        end else begin
            cmd_valid <= 1'b0;
            out_b_valid <= 1'b0;
            term_pulse <= 1'b0;
            clear_pulse <= 1'b0;
            if (cmd_end && hit && new_code == CYC_XFR_OUT_A) begin
                cmd_valid <= 1'b1; // see RL10
                cmd_data <= cmd_word_r[DATA_HI:DATA_LO];
            end
            if (cmd_end && hit && new_code == CYC_TERMINATE) begin
                term_pulse <= 1'b1; // see RL17
            end
            if (cmd_end && hit && new_code == CYC_CLEAR_TEST) begin
                clear_pulse <= 1'b1; // see RL14
                cmd_data <= DATA_ZERO;
                out_b_data <= WORD_ZERO;
            end
            if (rsp_end && state_r == ST_RESP && cyc_r == CYC_XFR_OUT_B) begin
                out_b_valid <= 1'b1; // see RL12
                out_b_data <= rsp_word_r;
            end
        end
    end

    a_attention_follows: assert property ( // see RL3
        @(posedge mclk) disable iff (!ctl_rst_n)
        ##1 attention_line == $past(service_needed))
        else $error("attention line does not follow service need");

    a_select_idle_low: assert property ( // see RL6
        @(posedge mclk) disable iff (!ctl_rst_n)
        (state_r == ST_IDLE) |-> !bus_drive_select && exch_oe == WORD_ZERO)
        else $error("exchange driven while idle");

    a_select_covers_drive: assert property ( // see RL5
        @(posedge mclk) disable iff (!ctl_rst_n)
        (exch_oe != WORD_ZERO) |-> bus_drive_select)
        else $error("exchange driven without direction select");

    a_outa_latch: assert property ( // see RL10
        @(posedge mclk) disable iff (!ctl_rst_n)
        (cmd_end && hit && new_code == CYC_XFR_OUT_A)
            |=> cmd_valid && cmd_data == $past(cmd_word_r[DATA_HI:DATA_LO]))
        else $error("transfer out A data not latched");

    a_outa_status: assert property ( // see RL11
        @(posedge mclk) disable iff (!ctl_rst_n)
        (state_r == ST_RESP && cyc_r == CYC_XFR_OUT_A)
            |-> exch_out[STAT_HI:STAT_LO] == $past(device_status) && bus_drive_select)
        else $error("transfer out A status missing");

    a_outb_capture: assert property ( // see RL12
        @(posedge mclk) disable iff (!ctl_rst_n)
        (rsp_end && state_r == ST_RESP && cyc_r == CYC_XFR_OUT_B)
            |=> out_b_valid && out_b_data == $past(rsp_word_r) ##1 !out_b_valid)
        else $error("transfer out B word not captured");

    a_test_reply: assert property ( // see RL13
        @(posedge mclk) disable iff (!ctl_rst_n)
        (state_r == ST_RESP && cyc_r == CYC_TEST_STATUS)
            |-> exch_out[PRESENT_BIT] && exch_out[ID_HI:ID_LO] == DEVICE_ID)
        else $error("test status reply malformed");

    a_clear_reply: assert property ( // see RL14
        @(posedge mclk) disable iff (!ctl_rst_n)
        (cmd_end && hit && new_code == CYC_CLEAR_TEST)
            |=> clear_pulse && exch_out[STAT_HI:STAT_LO] == STATUS_RESET)
        else $error("clear and test did not clear");

    a_poll_bit: assert property ( // see RL15
        @(posedge mclk) disable iff (!ctl_rst_n)
        (state_r == ST_RESP && cyc_r == CYC_POLL && $past(service_needed))
            |-> exch_oe[$past(my_channel)] && exch_out[$past(my_channel)])
        else $error("poll bit not driven");

    a_xfr_in_data: assert property ( // see RL18
        @(posedge mclk) disable iff (!ctl_rst_n)
        (state_r == ST_RESP && cyc_r == CYC_XFR_IN)
            |-> exch_out[DATA_HI:DATA_LO] == $past(in_data))
        else $error("transfer in data wrong");

    a_foreign_ignored: assert property ( // see RL24
        @(posedge mclk) disable iff (!ctl_rst_n)
        (cmd_end && !hit && state_r == ST_IDLE)
            |=> state_r == ST_IDLE && !cmd_valid && !clear_pulse && !term_pulse)
        else $error("control reacted to another channel");

    a_term_pulse: assert property ( // see RL17
        @(posedge mclk) disable iff (!ctl_rst_n)
        (cmd_end && hit && new_code == CYC_TERMINATE) |=> term_pulse ##1 !term_pulse)
        else $error("terminate not signalled");

endmodule : io_bus_control
`default_nettype wire

// ### verif/host_model.sv
// Processor side of the exchange bus: runs one two-phase cycle per request.
// Assumes the bench resolves the exchange wire and returns it on line_level.
`timescale 1ns/1ps
`default_nettype none
module host_model
    import io_bus_pkg::*;
(
    input wire logic mclk,
    input wire logic go,
    input wire logic write_b,
    input wire logic [3:0] gap,
    input wire logic [EXCH_W-1:0] cmd_word,
    input wire logic [EXCH_W-1:0] data_word,
    input wire logic [EXCH_W-1:0] line_level,
    output logic cmd_strobe,
    output logic response_strobe,
    output logic host_en,
    output logic [EXCH_W-1:0] host_val,
    output logic [EXCH_W-1:0] reply,
    output logic done
);
    // One whole word per phase, strobes change on the falling edge
    initial begin
        cmd_strobe = 1'b0;
        response_strobe = 1'b0;
        host_en = 1'b0;
        host_val = WORD_ZERO;
        reply = WORD_ZERO;
        done = 1'b0;
        forever begin
            @(posedge mclk);
            if (go && !done) begin
                @(negedge mclk);
                host_val = cmd_word;
                host_en = 1'b1;
                cmd_strobe = 1'b1;
                @(negedge mclk);
                cmd_strobe = 1'b0;
                host_en = 1'b0;
                repeat (gap) @(negedge mclk);
                host_val = data_word;
                host_en = write_b;
                response_strobe = 1'b1;
                @(posedge mclk);
                reply = line_level;
                @(negedge mclk);
                response_strobe = 1'b0;
                host_en = 1'b0;
                repeat (4) @(negedge mclk);
                done = 1'b1;
                wait (!go);
                done = 1'b0;
            end
        end
    end
endmodule : host_model
`default_nettype wire

// ### verif/test_io_bus_control.sv
// Self-checking bench for one exchange bus control.
// Assumes host_model as processor; released lines show a toggling pattern.
`timescale 1ns/1ps
`default_nettype none
module test_io_bus_control;
    import io_bus_pkg::*;
    logic mclk, nrst, sys_clear, cs, rs, go, wr, done, svc, hen, bds, att, cv, bv, tp, cp;
    logic [EXCH_W-1:0] line, eo, oe, cw, dw, hv, reply, idle_r, bdata, oe_seen;
    logic [STAT_W-1:0] st;
    logic [DATA_W-1:0] ind, cdata;
    logic [3:0] gap, chan;
    int n_fail, comparisons, n_cv, n_bv, n_tp, n_cp, n_drv;
    assign line = (oe & eo) | (~oe & (hen ? hv : idle_r));
    io_bus_control i_dut (.mclk(mclk), .nrst(nrst), .subsystem_clear(sys_clear),
        .cmd_strobe(cs), .response_strobe(rs), .exch_in(line), .exch_out(eo),
        .exch_oe(oe), .bus_drive_select(bds), .attention_line(att),
        .my_channel(chan), .service_needed(svc), .device_status(st), .in_data(ind),
        .cmd_valid(cv), .cmd_data(cdata), .out_b_valid(bv), .out_b_data(bdata),
        .term_pulse(tp), .clear_pulse(cp));
    host_model i_host (.mclk(mclk), .go(go), .write_b(wr), .gap(gap), .cmd_word(cw),
        .data_word(dw), .line_level(line), .cmd_strobe(cs), .response_strobe(rs),
        .host_en(hen), .host_val(hv), .reply(reply), .done(done));
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    // Pulse and drive monitors
    always @(posedge mclk) begin
        idle_r <= nrst ? ~idle_r : 24'hA5A5A5;
        n_cv += (cv === 1'b1);
        n_bv += (bv === 1'b1);
        n_tp += (tp === 1'b1);
        n_cp += (cp === 1'b1);
        n_drv += (bds === 1'b1);
        oe_seen |= oe;
    end
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic run(input logic [23:0] c, input logic [23:0] d, input logic w,
        input logic [3:0] g);
        int k;
        @(negedge mclk);
        cw = c;
        dw = d;
        wr = w;
        gap = g;
        go = 1'b1;
        n_cv = 0;
        n_bv = 0;
        n_tp = 0;
        n_cp = 0;
        n_drv = 0;
        oe_seen = WORD_ZERO;
        for (k = 0; k < 200 && done !== 1'b1; k++) @(negedge mclk);
        go = 1'b0;
        if (k >= 200) n_fail++;
        @(negedge mclk);
    endtask : run
    task automatic t_out_a;
        st = 5'h15;
        run({CYC_XFR_OUT_A, 4'h3, 16'h1234}, WORD_ZERO, 1'b0, 4'h2);
        check("cmd_data", 24'(cdata), 24'h001234);
        check("cmd_valid", 24'(n_cv), 24'h1);
        check("status", 24'(reply[STAT_HI:STAT_LO]), 24'h15);
        check("select", 24'(n_drv > 0), 24'h1);
        check("idle select", 24'(bds), 24'h0);
        check("idle oe", oe, WORD_ZERO);
        $display("test out_a done");
    endtask : t_out_a
    task automatic t_refused;
        for (int i = 0; i < 2; i++) begin
            run(i == 0 ? {CYC_XFR_OUT_A, 4'h5, 16'h5555} : 24'hF35555, WORD_ZERO, 1'b0, 4'h2);
            check("cmd_valid", 24'(n_cv), 24'h0);
            check("select", 24'(n_drv), 24'h0);
            check("oe", oe_seen, WORD_ZERO);
        end
        $display("test refused done");
    endtask : t_refused
    task automatic t_out_b;
        run({CYC_XFR_OUT_B, 4'h3, 16'h0000}, 24'hABCDEF, 1'b1, 4'h3);
        check("out_b_data", bdata, 24'hABCDEF);
        check("out_b_valid", 24'(n_bv), 24'h1);
        check("select", 24'(n_drv), 24'h0);
        $display("test out_b done");
    endtask : t_out_b
    task automatic t_status;
        st = 5'h0A;
        run({CYC_TEST_STATUS, 4'h3, 16'h0000}, WORD_ZERO, 1'b0, 4'h2);
        check("status", 24'(reply[STAT_HI:STAT_LO]), 24'h0A);
        check("id", 24'(reply[ID_HI:ID_LO]), 24'(DEVICE_ID_DEFAULT));
        check("present", 24'(reply[PRESENT_BIT]), 24'h1);
        st = 5'h1F;
        run({CYC_CLEAR_TEST, 4'h3, 16'h0000}, WORD_ZERO, 1'b0, 4'h2);
        check("clear_pulse", 24'(n_cp), 24'h1);
        check("reset status", 24'(reply[STAT_HI:STAT_LO]), 24'(STATUS_RESET));
        check("cmd_data", 24'(cdata), 24'h0);
        $display("test status done");
    endtask : t_status
    task automatic t_poll;
        svc = 1'b1;
        repeat (2) @(negedge mclk);
        check("attention", 24'(att), 24'h1);
        run({CYC_POLL, 4'hF, 16'h0000}, WORD_ZERO, 1'b0, 4'h2);
        check("poll bit", 24'(reply[3]), 24'h1);
        check("poll oe", oe_seen, 24'h000008);
        chan = 4'hB;
        run({CYC_POLL, 4'hF, 16'h0000}, WORD_ZERO, 1'b0, 4'h2);
        check("poll bit other", 24'(reply[11]), 24'h1);
        check("poll oe other", oe_seen, 24'h000800);
        chan = 4'h3;
        check("attention held", 24'(att), 24'h1);
        svc = 1'b0;
        repeat (2) @(negedge mclk);
        check("attention off", 24'(att), 24'h0);
        $display("test poll done");
    endtask : t_poll
    task automatic t_term_in;
        st = 5'h07;
        ind = 16'hBEEF;
        run({CYC_TERMINATE, 4'h3, 16'h0000}, WORD_ZERO, 1'b0, 4'h2);
        check("term_pulse", 24'(n_tp), 24'h1);
        check("status", 24'(reply[STAT_HI:STAT_LO]), 24'h07);
        run({CYC_XFR_IN, 4'h3, 16'h0000}, WORD_ZERO, 1'b0, 4'h5);
        check("in data", 24'(reply[DATA_HI:DATA_LO]), 24'h00BEEF);
        check("select", 24'(n_drv > 0), 24'h1);
        $display("test term_in done");
    endtask : t_term_in
    task automatic t_clear;
        fork
            run({CYC_TEST_STATUS, 4'h3, 16'h0000}, WORD_ZERO, 1'b0, 4'h9);
            begin
                for (int k = 0; k < 50 && bds !== 1'b1; k++) @(negedge mclk);
                sys_clear = 1'b1;
                #1;
                check("cleared select", 24'(bds), 24'h0);
                check("cleared oe", oe, WORD_ZERO);
                repeat (3) @(negedge mclk);
                sys_clear = 1'b0;
            end
        join
        check("select after", 24'(bds), 24'h0);
        $display("test clear done");
    endtask : t_clear
    task automatic wrap_up;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : wrap_up
    initial begin
        #20000;
        n_fail++;
        wrap_up;
    end
    initial begin
        nrst = 1'b0;
        sys_clear = 1'b0;
        chan = 4'h3;
        go = 1'b0;
        svc = 1'b0;
        st = 5'h00;
        ind = DATA_ZERO;
        n_fail = 0;
        comparisons = 0;
        repeat (6) @(negedge mclk);
        nrst = 1'b1;
        repeat (3) @(negedge mclk);
        t_out_a;
        t_refused;
        t_out_b;
        t_status;
        t_poll;
        t_term_in;
        t_clear;
        wrap_up;
    end
endmodule : test_io_bus_control
`default_nettype wire
